//--- rtl/htrs_route_select.sv
// host transmit route selector: picks serial port or usb for outgoing bytes
// single clock; straps and host-side pins are taken as already synchronous
`timescale 1ns/1ps
module htrs_route_select
  import htrs_pkg::*;
#(
  parameter int INIT_CYCLES = HTRS_INIT_CYCLES
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic serial_mode_strap_a,
  input wire logic serial_mode_strap_b,
  input wire logic test_strap_n,
  input wire logic usb_active,
  input wire logic usb_ep1_in_req,
  input wire logic serial_rx_byte,
  input wire logic setup_end_cmd,
  input wire logic core_rx_busy,
  input wire htrs_byte_t tx_data,
  input wire logic tx_valid,
  output logic tx_ready,
  output htrs_byte_t ser_data,
  output logic ser_valid,
  input wire logic ser_ready,
  output htrs_byte_t usb_data,
  output logic usb_valid,
  input wire logic usb_ready,
  output htrs_mode_t serial_mode,
  output logic test_mode,
  output logic route_usb,
  output logic init_done,
  output logic module_busy_out,
  output logic module_busy_oe,
  output logic txd_oe,
  output logic trdy_out,
  output logic trdy_oe
);

  ////////////////////////////////////////////////////////////////////////
  // strap capture and initialisation timer

  localparam int CW = $clog2(INIT_CYCLES + 1);

  logic [CW-1:0] init_cnt_r, init_cnt_nxt;
  logic init_done_r, init_done_nxt;
  htrs_mode_t serial_mode_r, serial_mode_nxt;
  logic test_mode_r, test_mode_nxt;
  logic straps_taken_r, straps_taken_nxt;

  function automatic htrs_mode_t decode_mode(input logic a, input logic b);
    unique case ({a, b})
      HTRS_STRAP_UART: decode_mode = HTRS_MODE_UART;
      HTRS_STRAP_SPI: decode_mode = HTRS_MODE_SPI;
      HTRS_STRAP_I2C: decode_mode = HTRS_MODE_I2C;
      // strap a open, b shorted is undefined; fall back to the open default
      default: decode_mode = HTRS_MODE_SPI;
    endcase
  endfunction

  always_comb begin
    init_cnt_nxt = init_cnt_r;
    init_done_nxt = init_done_r;
    serial_mode_nxt = serial_mode_r;
    test_mode_nxt = test_mode_r;
    straps_taken_nxt = straps_taken_r;
    // straps are sampled once on the first edge after release, never in reset
    // a moved jumper takes effect only after the next reset
    if (!straps_taken_r) begin
      straps_taken_nxt = 1'b1;
      serial_mode_nxt = decode_mode(serial_mode_strap_a, serial_mode_strap_b);
      test_mode_nxt = ~test_strap_n;
    end
    // the timer starts at release, so a short reset pulse still gives the full init time
    if (!init_done_r) begin
      if (init_cnt_r == CW'(INIT_CYCLES - 1)) begin
        init_done_nxt = 1'b1;
      end else begin
        init_cnt_nxt = init_cnt_r + CW'(1);
      end
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      init_cnt_r <= '0;
      init_done_r <= 1'b0;
      serial_mode_r <= HTRS_MODE_SPI;
      test_mode_r <= 1'b0;
      straps_taken_r <= 1'b0;
    end else begin
      init_cnt_r <= init_cnt_nxt;
      init_done_r <= init_done_nxt;
      serial_mode_r <= serial_mode_nxt;
      test_mode_r <= test_mode_nxt;
      straps_taken_r <= straps_taken_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // routing state machine

  htrs_route_t route_r, route_nxt;
  logic route_usb_r, route_usb_nxt;
  logic out_busy;

  function automatic logic is_usb(input htrs_route_t rt);
    is_usb = (rt == HTRS_RT_USB);
  endfunction

  always_comb begin
    route_nxt = route_r;
    // a clear command beats a usb request in the same cycle; a serial byte beats both
    // a read attempt that meets a byte in flight is dropped, not held; the host retries it
    unique case (route_r)
      HTRS_RT_SERIAL: begin
        if (serial_rx_byte) begin
          route_nxt = HTRS_RT_LOCKED;
        end else if (usb_active && usb_ep1_in_req && !setup_end_cmd && !out_busy) begin
          route_nxt = HTRS_RT_USB;
        end
      end
      HTRS_RT_USB: begin
        if (serial_rx_byte) begin
          route_nxt = HTRS_RT_LOCKED;
        end else if (setup_end_cmd) begin
          route_nxt = HTRS_RT_SERIAL;
        end
      end
      HTRS_RT_LOCKED: begin
        // usb reads are ignored here; only setup end or reset leaves the lock
        if (setup_end_cmd && !serial_rx_byte) begin
          route_nxt = HTRS_RT_SERIAL;
        end
      end
      default: route_nxt = HTRS_RT_SERIAL;
    endcase
    // registered off the next state, so the pin tracks route_r exactly
    route_usb_nxt = is_usb(route_nxt);
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      route_r <= HTRS_RT_SERIAL;
      route_usb_r <= 1'b0;
    end else begin
      route_r <= route_nxt;
      route_usb_r <= route_usb_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // two-entry buffer in the transmit path

  htrs_byte_t buf_r [2];
  htrs_byte_t buf_nxt [2];
  logic [1:0] cnt_r, cnt_nxt;
  logic rd_r, rd_nxt;
  logic wr_r, wr_nxt;
  logic to_usb_r, to_usb_nxt;
  logic in_flight_r, in_flight_nxt;
  logic take;
  logic pop;
  logic dst_ready;

  // occupancy tests shared by the input side and the pin flags; the output
  // register is a third slot, so up to three bytes can wait in the path
  function automatic logic buf_full(input logic [1:0] n);
    buf_full = (n == HTRS_BUF_DEPTH);
  endfunction

  function automatic logic buf_empty(input logic [1:0] n);
    buf_empty = (n == HTRS_BUF_NONE);
  endfunction

  // a switch to usb is only made while no byte is held at an output; serial byte and setup end act at any time
  assign out_busy = in_flight_r;
  assign dst_ready = to_usb_r ? usb_ready : ser_ready;
  assign take = tx_valid && !buf_full(cnt_r) && init_done_r;
  assign pop = !buf_empty(cnt_r) && (!in_flight_r || dst_ready);

  always_comb begin
    buf_nxt[0] = buf_r[0];
    buf_nxt[1] = buf_r[1];
    cnt_nxt = cnt_r;
    rd_nxt = rd_r;
    wr_nxt = wr_r;
    to_usb_nxt = to_usb_r;
    in_flight_nxt = in_flight_r;
    if (in_flight_r && dst_ready) begin
      in_flight_nxt = 1'b0;
    end
    if (take) begin
      buf_nxt[wr_r] = tx_data;
      wr_nxt = ~wr_r;
    end
    if (pop) begin
      rd_nxt = ~rd_r;
      in_flight_nxt = 1'b1;
      // follow the route being entered, so a byte launched as the route flips goes to the new port
      to_usb_nxt = is_usb(route_nxt);
    end
    cnt_nxt = cnt_r + {1'b0, take} - {1'b0, pop};
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      buf_r[0] <= '{data: HTRS_BYTE_ZERO};
      buf_r[1] <= '{data: HTRS_BYTE_ZERO};
      cnt_r <= HTRS_BUF_NONE;
      rd_r <= 1'b0;
      wr_r <= 1'b0;
      to_usb_r <= 1'b0;
      in_flight_r <= 1'b0;
    end else begin
      buf_r[0] <= buf_nxt[0];
      buf_r[1] <= buf_nxt[1];
      cnt_r <= cnt_nxt;
      rd_r <= rd_nxt;
      wr_r <= wr_nxt;
      to_usb_r <= to_usb_nxt;
      in_flight_r <= in_flight_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // registered outputs

  htrs_byte_t out_data_r, out_data_nxt;
  logic tx_ready_r, tx_ready_nxt;
  logic busy_r, busy_nxt;
  logic oe_r, oe_nxt;
  logic trdy_r, trdy_nxt;
  logic ser_valid_r, ser_valid_nxt;
  logic usb_valid_r, usb_valid_nxt;

  always_comb begin
    out_data_nxt = out_data_r;
    if (pop) begin
      out_data_nxt = buf_r[rd_r];
    end
    // ready and trdy look at the next count so the pins agree with the buffer after this edge
    tx_ready_nxt = init_done_nxt && !buf_full(cnt_nxt);
    // busy also mirrors the receive side, so the host pauses while input is full
    busy_nxt = !init_done_nxt || core_rx_busy;
    // one enable flop for all three pins: they leave high impedance together
    oe_nxt = init_done_nxt;
    trdy_nxt = !buf_empty(cnt_nxt);
    ser_valid_nxt = in_flight_nxt && !to_usb_nxt;
    usb_valid_nxt = in_flight_nxt && to_usb_nxt;
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      out_data_r <= '{data: HTRS_BYTE_ZERO};
      tx_ready_r <= 1'b0;
      busy_r <= 1'b1;
      oe_r <= 1'b0;
      trdy_r <= 1'b0;
      ser_valid_r <= 1'b0;
      usb_valid_r <= 1'b0;
    end else begin
      out_data_r <= out_data_nxt;
      tx_ready_r <= tx_ready_nxt;
      busy_r <= busy_nxt;
      oe_r <= oe_nxt;
      trdy_r <= trdy_nxt;
      ser_valid_r <= ser_valid_nxt;
      usb_valid_r <= usb_valid_nxt;
    end
  end

  // valid flags are registered copies of in-flight and destination, so every pin leaves a flop
  assign ser_valid = ser_valid_r;
  assign usb_valid = usb_valid_r;

  assign tx_ready = tx_ready_r;
  assign ser_data = out_data_r;
  assign usb_data = out_data_r;
  assign serial_mode = serial_mode_r;
  assign test_mode = test_mode_r;
  assign route_usb = route_usb_r;
  assign init_done = init_done_r;
  assign module_busy_out = busy_r;
  assign module_busy_oe = oe_r;
  assign txd_oe = oe_r;
  assign trdy_out = trdy_r;
  assign trdy_oe = oe_r;

endmodule

//--- rtl/htrs_pkg.sv
// package for the host transmit route selector: types and constants
package htrs_pkg;

  // serial protocol chosen by the two mode straps (open = 1, short = 0)
  typedef enum logic [1:0] {
    HTRS_MODE_UART = 2'b00,
    HTRS_MODE_SPI = 2'b01,
    HTRS_MODE_I2C = 2'b10
  } htrs_mode_t;

  // strap pattern {strap_a, strap_b}
  localparam logic [1:0] HTRS_STRAP_UART = 2'h0;
  localparam logic [1:0] HTRS_STRAP_SPI = 2'h3;
  localparam logic [1:0] HTRS_STRAP_I2C = 2'h1;

  // routing states
  typedef enum logic [1:0] {
    HTRS_RT_SERIAL = 2'b00,
    HTRS_RT_USB = 2'b01,
    HTRS_RT_LOCKED = 2'b10
  } htrs_route_t;

  // internal initialisation time after reset release
  localparam int HTRS_INIT_TIME_NS = 1000;
  localparam int HTRS_CLK_PERIOD_NS = 10;
  localparam int HTRS_INIT_CYCLES = (HTRS_INIT_TIME_NS + HTRS_CLK_PERIOD_NS - 1) / HTRS_CLK_PERIOD_NS;
  localparam int HTRS_BYTE_W = 8;

  // transmit buffer occupancy limits
  localparam logic [1:0] HTRS_BUF_DEPTH = 2'h2;
  localparam logic [1:0] HTRS_BUF_NONE = 2'h0;

  // one transmit byte travelling through the buffer
  typedef struct packed {
    logic [HTRS_BYTE_W-1:0] data;
  } htrs_byte_t;

  localparam logic [HTRS_BYTE_W-1:0] HTRS_BYTE_ZERO = 8'h00;

endpackage

//--- sim/htrs_route_select_asserts.sv
// checker for the host transmit route selector, bound to its ports
`timescale 1ns/1ps
module htrs_route_select_asserts
  import htrs_pkg::*;
#(
  parameter int INIT_CYCLES = HTRS_INIT_CYCLES
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic usb_active,
  input wire logic usb_ep1_in_req,
  input wire logic serial_rx_byte,
  input wire logic setup_end_cmd,
  input wire logic tx_ready,
  input wire htrs_byte_t ser_data,
  input wire logic ser_valid,
  input wire logic ser_ready,
  input wire htrs_byte_t usb_data,
  input wire logic usb_valid,
  input wire logic usb_ready,
  input wire logic route_usb,
  input wire logic init_done,
  input wire logic module_busy_out,
  input wire logic module_busy_oe,
  input wire logic txd_oe,
  input wire logic trdy_oe
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  // a serial byte followed at once by a usb read attempt
  sequence s_lock_then_req;
    serial_rx_byte ##1 (usb_active && usb_ep1_in_req);
  endsequence
  a_lock_ignores_usb: assert property (s_lock_then_req |=> !route_usb)
    else $error("usb request switched a locked route");
  a_rx_locks: assert property (serial_rx_byte |=> !route_usb)
    else $error("serial byte did not pull route to serial");
  a_usb_cause: assert property ($rose(route_usb) |-> $past(usb_active) && $past(usb_ep1_in_req))
    else $error("route went to usb without a read attempt");
  a_setup_clear: assert property (setup_end_cmd && !serial_rx_byte |=> !route_usb)
    else $error("setup end did not restore serial route");
  a_ser_hold: assert property (ser_valid && !ser_ready |=> ser_valid && $stable(ser_data))
    else $error("serial byte changed while stalled");
  a_usb_hold: assert property (usb_valid && !usb_ready |=> usb_valid && $stable(usb_data))
    else $error("usb byte changed while stalled");
  a_one_port: assert property (!(ser_valid && usb_valid))
    else $error("byte offered on both ports");
  a_ser_route: assert property (ser_valid |-> !route_usb)
    else $error("serial byte offered while routed to usb");
  a_init_quiet: assert property (!init_done |-> !(module_busy_oe || txd_oe || trdy_oe) && module_busy_out && !tx_ready)
    else $error("outputs active before init done");
endmodule
bind htrs_route_select htrs_route_select_asserts #(.INIT_CYCLES(INIT_CYCLES)) chk_i (.*);

//--- sim/htrs_host_model.sv
// host side sink for the serial and usb byte streams
`timescale 1ns/1ps
module htrs_host_model
  import htrs_pkg::*;
(
  input wire logic clk,
  input wire logic stall,
  input wire htrs_byte_t ser_data,
  input wire logic ser_valid,
  output logic ser_ready,
  input wire htrs_byte_t usb_data,
  input wire logic usb_valid,
  output logic usb_ready
);
  // entries hold {came_by_usb, byte}
  logic [8:0] got[$];
  assign ser_ready = !stall;
  assign usb_ready = !stall;
  always @(posedge clk) begin
    if (ser_valid && ser_ready) got.push_back({1'b0, ser_data.data});
    if (usb_valid && usb_ready) got.push_back({1'b1, usb_data.data});
  end
endmodule

//--- sim/tb.sv
// testbench for the host transmit route selector
`timescale 1ns/1ps
module tb;
  import htrs_pkg::*;
  logic clk = 0, nrst = 0, serial_mode_strap_a = 1, serial_mode_strap_b = 1, test_strap_n = 1;
  logic usb_active = 0, usb_ep1_in_req = 0, serial_rx_byte = 0, setup_end_cmd = 0, core_rx_busy = 0;
  logic tx_valid = 0, stall = 0, tx_ready, ser_valid, ser_ready, usb_valid, usb_ready, test_mode, route_usb;
  logic init_done, module_busy_out, module_busy_oe, txd_oe, trdy_out, trdy_oe;
  htrs_byte_t tx_data = '0, ser_data, usb_data;
  htrs_mode_t serial_mode;
  int mismatches = 0, num_checks = 0, cyc = 0, i;
  logic [8:0] exp[$];
  logic [1:0] pat[4] = '{2'h0, 2'h3, 2'h1, 2'h2};
  htrs_mode_t mode_w[4] = '{HTRS_MODE_UART, HTRS_MODE_SPI, HTRS_MODE_I2C, HTRS_MODE_SPI};
  htrs_route_select #(.INIT_CYCLES(4)) uut (.*);
  htrs_host_model host (.*);
  always #5 clk = ~clk;
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      mismatches++;
      test_done;
    end
  end
  task chk(input logic [8:0] got, input logic [8:0] want);
    num_checks++;
    if (got !== want) begin
      mismatches++;
      $display("BAD %0t got %h want %h", $time, got, want);
    end
  endtask
  task do_reset(input logic [1:0] st, input logic t);
    nrst = 0;
    {serial_mode_strap_a, serial_mode_strap_b} = st;
    test_strap_n = t;
    repeat (5) @(negedge clk);
    chk(module_busy_oe | txd_oe | trdy_oe, 9'h000);
    nrst = 1;
    repeat (2) @(negedge clk);
    chk({init_done, module_busy_oe}, 9'h000);
    repeat (40) if (!init_done) @(negedge clk);
    chk({init_done, module_busy_oe, module_busy_out}, 9'h006);
    chk({txd_oe, trdy_oe, trdy_out}, 9'h006);
  endtask
  task automatic pulse(ref logic s);
    s = 1;
    @(negedge clk);
    s = 0;
  endtask
  task push(input logic u, input logic [7:0] d);
    tx_data.data = d;
    tx_valid = 1;
    exp.push_back({u, d});
    while (!tx_ready) @(negedge clk);
    @(negedge clk);
  endtask
  task drain;
    tx_valid = 0;
    stall = 0;
    repeat (10) @(negedge clk);
    chk(9'(host.got.size()), 9'(exp.size()));
    while (exp.size() > 0) chk(host.got.pop_front(), exp.pop_front());
  endtask
  task test_done;
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  initial begin
    for (i = 0; i < 4; i++) begin
      do_reset(pat[i], i[0]);
      chk(serial_mode, mode_w[i]);
      chk(test_mode, !i[0]);
    end
    do_reset(2'h3, 1);
    stall = 1;
    for (i = 0; i < 8 && tx_ready; i++) push(0, 8'(8'h10 + i));
    chk(tx_ready, 9'h000);
    chk(trdy_out, 9'h001);
    drain;
    chk(trdy_out, 9'h000);
    pulse(usb_ep1_in_req);
    chk(route_usb, 9'h000);
    usb_active = 1;
    pulse(usb_ep1_in_req);
    chk(route_usb, 9'h001);
    push(1, 8'ha5);
    push(1, 8'h5a);
    drain;
    pulse(serial_rx_byte);
    chk(route_usb, 9'h000);
    pulse(usb_ep1_in_req);
    chk(route_usb, 9'h000);
    push(0, 8'h3c);
    drain;
    pulse(setup_end_cmd);
    pulse(usb_ep1_in_req);
    chk(route_usb, 9'h001);
    pulse(setup_end_cmd);
    chk(route_usb, 9'h000);
    do_reset(2'h3, 1);
    chk(route_usb, 9'h000);
    core_rx_busy = 1;
    repeat (2) @(negedge clk);
    chk(module_busy_out, 9'h001);
    core_rx_busy = 0;
    repeat (2) @(negedge clk);
    chk(module_busy_out, 9'h000);
    test_done;
  end
endmodule
